//--- include/uart_shadow_pkg.sv
package uart_shadow_pkg;
   // alias window: sixteen word locations, byte addresses
   localparam logic [31:0] ALIAS_BASE                = 32'h5000_1030;
   localparam logic [31:0] SHADOW_RX_TX_DATA_ALIAS_1 = 32'h5000_1034;
   localparam logic [31:0] ALIAS_SPAN                = 32'h0000_0040;
   localparam logic [15:0] ALIAS_RESET               = 16'h0000;
   // control, status and interrupt registers
   localparam logic [31:0] CTRL_ADDR                 = 32'h5000_1100;
   localparam logic [31:0] LINE_STATUS_ADDR          = 32'h5000_1104;
   localparam logic [31:0] INT_STATUS_ADDR           = 32'h5000_1108;
   localparam logic [31:0] INT_CLEAR_ADDR            = 32'h5000_110c;
   localparam logic [31:0] INT_ENABLE_ADDR           = 32'h5000_1110;
   // field positions, widths and fifo depth
   localparam int          CTRL_FIFO_EN_BIT          = 0;
   localparam int          CTRL_IR_MODE_BIT          = 1;
   localparam int          LS_DATA_READY_BIT         = 0;
   localparam int          LS_OVERRUN_BIT            = 1;
   localparam int          LS_TX_EMPTY_BIT           = 5;
   localparam int          INT_RX_BIT                = 0;
   localparam int          INT_OVERRUN_BIT           = 1;
   localparam int          INT_TX_EMPTY_BIT          = 2;
   localparam int          INT_W                     = 3;
   localparam int          DATA_W                    = 8;
   localparam int          FIFO_DEPTH                = 16;
   // cycles a fifo head needs to reach the transmit output flop
   localparam logic [1:0]  TX_SETTLE                 = 2'h2;
   // apb slave states
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WAIT = 3'b010,
      BUS_RESP = 3'b100
   } bus_state_t;
endpackage : uart_shadow_pkg

//--- verilog/byte_store.sv
`timescale 1ns/1ps
`default_nettype none
module byte_store #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output var  logic [WIDTH-1:0] rdata
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0]            rdata;
   } store_t;

   store_t state_reg;
   store_t state_next;

   // write port, registered read of the addressed entry
   always_comb begin
      state_next = state_reg;
      if (we) begin
         state_next.mem[waddr] = wdata;
      end
      state_next.rdata = state_reg.mem[raddr];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata = state_reg.rdata;
endmodule : byte_store
`default_nettype wire

//--- verilog/uart_shadow_data_port.sv
// Contract
// - Sixteen consecutive word addresses all decode as the same receive/transmit data alias.
// - An alias read returns the byte from the serial input, or from the infrared input in infrared mode.
// - Read data is valid only while data-ready is set, and software checks that flag first.
// - With fifos off, a byte arriving before the held one is read overwrites it and flags overrun.
// - With fifos on, an alias read returns and pops the oldest receive fifo entry.
// - A byte arriving at a full receive fifo with no alias read in the same cycle is dropped, the fifo is kept and overrun is flagged.
// - An alias write supplies a byte for the serial output, or the infrared output in infrared mode.
// - With fifos off and the empty flag set, one write loads the holding byte and clears the flag.
// - With fifos off, further writes before the flag sets again replace the pending byte.
// - With fifos on, the transmit fifo accepts writes up to its depth, sixteen by default.
// - A write while the transmit fifo is full is discarded, and with no pop in the same cycle the fifo is unchanged.
`timescale 1ns/1ps
`default_nettype none
module uart_shadow_data_port #(
   parameter int DEPTH = uart_shadow_pkg::FIFO_DEPTH,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        rx_in_valid,
   input  wire logic [7:0]  rx_in_data,
   input  wire logic        ir_rx_in_valid,
   input  wire logic [7:0]  ir_rx_in_data,
   input  wire logic        tx_taken,
   output var  logic [7:0]  tx_data,
   output var  logic        tx_valid,
   output var  logic        tx_ir_mode,
   output var  logic        rx_data_ready,
   output var  logic        tx_holding_empty,
   output var  logic        overrun_err,
   output var  logic        irq
);
   localparam int             CW       = AW + 1;
   localparam logic [CW-1:0]  CNT_FULL = CW'(DEPTH);
   localparam int             IW       = uart_shadow_pkg::INT_W;

   typedef struct packed {
      uart_shadow_pkg::bus_state_t st;
      logic [31:0]                 prdata;
      logic                        pready;
      logic                        pslverr;
      logic                        fifo_en;
      logic                        ir_mode;
      logic [7:0]                  rx_hold;
      logic                        rx_hold_full;
      logic [AW-1:0]               rx_wp;
      logic [AW-1:0]               rx_rp;
      logic [CW-1:0]               rx_cnt;
      logic [7:0]                  tx_hold;
      logic                        tx_hold_full;
      logic [AW-1:0]               tx_wp;
      logic [AW-1:0]               tx_rp;
      logic [CW-1:0]               tx_cnt;
      logic [1:0]                  tx_settle;
      logic [7:0]                  tx_data;
      logic                        tx_valid;
      logic                        rx_ready;
      logic                        tx_empty;
      logic                        ovr;
      logic [IW-1:0]               int_stat;
      logic [IW-1:0]               int_en;
      logic                        irq;
   } state_t;

   state_t        state_reg;
   state_t        state_next;
   logic          alias_hit;
   logic          mapped;
   logic          done;
   logic          rd_alias;
   logic          wr_alias;
   logic          in_v;
   logic [7:0]    in_d;
   logic          hold_pop;
   logic          rx_fpop;
   logic          rx_push;
   logic          tx_push;
   logic          tx_pop;
   logic          ovr_ev;
   logic          ctrl_wr;
   logic          flush;
   logic [7:0]    rx_rdata;
   logic [7:0]    tx_rdata;
   logic [IW-1:0] ev;

   // address decode and bus completion
   assign alias_hit = ((paddr - uart_shadow_pkg::ALIAS_BASE) < uart_shadow_pkg::ALIAS_SPAN)
                      && (paddr[1:0] == 2'h0);
   assign mapped    = alias_hit || paddr == uart_shadow_pkg::CTRL_ADDR
                      || paddr == uart_shadow_pkg::LINE_STATUS_ADDR
                      || paddr == uart_shadow_pkg::INT_STATUS_ADDR
                      || paddr == uart_shadow_pkg::INT_CLEAR_ADDR
                      || paddr == uart_shadow_pkg::INT_ENABLE_ADDR;
   assign done      = (state_reg.st == uart_shadow_pkg::BUS_RESP) && psel && penable;
   assign rd_alias  = done && !pwrite && alias_hit;
   assign wr_alias  = done && pwrite && alias_hit;
   assign ctrl_wr   = done && pwrite && paddr == uart_shadow_pkg::CTRL_ADDR;
   assign flush     = ctrl_wr && (pwdata[uart_shadow_pkg::CTRL_FIFO_EN_BIT] != state_reg.fifo_en);

   // receive source follows the line mode
   assign in_v = state_reg.ir_mode ? ir_rx_in_valid : rx_in_valid;
   assign in_d = state_reg.ir_mode ? ir_rx_in_data : rx_in_data;

   // receive and transmit queue steering
   assign hold_pop = rd_alias && !state_reg.fifo_en;
   assign rx_fpop  = rd_alias && state_reg.fifo_en && state_reg.rx_cnt != '0;
   assign rx_push  = in_v && state_reg.fifo_en && (state_reg.rx_cnt != CNT_FULL || rx_fpop);
   assign ovr_ev   = in_v && (state_reg.fifo_en ? !rx_push
                                                : (state_reg.rx_hold_full && !hold_pop));
   assign tx_push  = wr_alias && state_reg.fifo_en && state_reg.tx_cnt != CNT_FULL;
   assign tx_pop   = tx_taken && state_reg.tx_valid && state_reg.fifo_en;

   byte_store #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) rx_store (
      .pclk    (pclk),
      .presetn (presetn),
      .we      (rx_push),
      .waddr   (state_reg.rx_wp),
      .wdata   (in_d),
      .raddr   (state_reg.rx_rp),
      .rdata   (rx_rdata)
   );

   byte_store #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) tx_store (
      .pclk    (pclk),
      .presetn (presetn),
      .we      (tx_push),
      .waddr   (state_reg.tx_wp),
      .wdata   (pwdata[7:0]),
      .raddr   (state_reg.tx_rp),
      .rdata   (tx_rdata)
   );

   // next state of the whole block
   always_comb begin
      state_next = state_reg;
      case (state_reg.st)
         uart_shadow_pkg::BUS_IDLE: begin
            if (psel && !penable) begin
               state_next.st = uart_shadow_pkg::BUS_WAIT;
            end
         end
         uart_shadow_pkg::BUS_WAIT: begin
            state_next.st      = uart_shadow_pkg::BUS_RESP;
            state_next.pready  = 1'b1;
            state_next.pslverr = !mapped;
            state_next.prdata  = '0;
            if (pwrite) begin
               state_next.prdata = '0;
            end else if (alias_hit) begin
               state_next.prdata[7:0] = state_reg.fifo_en ? rx_rdata : state_reg.rx_hold;
            end else if (paddr == uart_shadow_pkg::CTRL_ADDR) begin
               state_next.prdata[uart_shadow_pkg::CTRL_FIFO_EN_BIT] = state_reg.fifo_en;
               state_next.prdata[uart_shadow_pkg::CTRL_IR_MODE_BIT] = state_reg.ir_mode;
            end else if (paddr == uart_shadow_pkg::LINE_STATUS_ADDR) begin
               state_next.prdata[uart_shadow_pkg::LS_DATA_READY_BIT] = state_reg.rx_ready;
               state_next.prdata[uart_shadow_pkg::LS_OVERRUN_BIT]    =
                  state_reg.int_stat[uart_shadow_pkg::INT_OVERRUN_BIT];
               state_next.prdata[uart_shadow_pkg::LS_TX_EMPTY_BIT]   = state_reg.tx_empty;
            end else if (paddr == uart_shadow_pkg::INT_STATUS_ADDR) begin
               state_next.prdata[IW-1:0] = state_reg.int_stat;
            end else if (paddr == uart_shadow_pkg::INT_ENABLE_ADDR) begin
               state_next.prdata[IW-1:0] = state_reg.int_en;
            end
         end
         uart_shadow_pkg::BUS_RESP: begin
            if (done) begin
               state_next.st      = uart_shadow_pkg::BUS_IDLE;
               state_next.pready  = 1'b0;
               state_next.pslverr = 1'b0;
               state_next.prdata  = '0;
            end
         end
         default: begin
            state_next.st     = uart_shadow_pkg::BUS_IDLE;
            state_next.pready = 1'b0;
         end
      endcase

      // control and interrupt enable writes
      if (ctrl_wr) begin
         state_next.fifo_en = pwdata[uart_shadow_pkg::CTRL_FIFO_EN_BIT];
         state_next.ir_mode = pwdata[uart_shadow_pkg::CTRL_IR_MODE_BIT];
      end
      if (done && pwrite && paddr == uart_shadow_pkg::INT_ENABLE_ADDR) begin
         state_next.int_en = pwdata[IW-1:0];
      end

      // single receive holding byte, overwritten when unread
      if (hold_pop) begin
         state_next.rx_hold_full = 1'b0;
      end
      if (in_v && !state_reg.fifo_en) begin
         state_next.rx_hold      = in_d;
         state_next.rx_hold_full = 1'b1;
      end

      // receive fifo pointers
      if (rx_push) begin
         state_next.rx_wp = state_reg.rx_wp + AW'(1);
      end
      if (rx_fpop) begin
         state_next.rx_rp = state_reg.rx_rp + AW'(1);
      end
      state_next.rx_cnt = state_reg.rx_cnt + CW'(rx_push) - CW'(rx_fpop);

      // single transmit holding byte, last write wins
      if (tx_taken && state_reg.tx_valid && !state_reg.fifo_en) begin
         state_next.tx_hold_full = 1'b0;
      end
      if (wr_alias && !state_reg.fifo_en) begin
         state_next.tx_hold      = pwdata[7:0];
         state_next.tx_hold_full = 1'b1;
      end

      // transmit fifo pointers
      if (tx_push) begin
         state_next.tx_wp = state_reg.tx_wp + AW'(1);
      end
      if (tx_pop) begin
         state_next.tx_rp = state_reg.tx_rp + AW'(1);
      end
      state_next.tx_cnt = state_reg.tx_cnt + CW'(tx_push) - CW'(tx_pop);

      // fifo mode change empties both paths
      if (flush) begin
         state_next.rx_wp        = '0;
         state_next.rx_rp        = '0;
         state_next.rx_cnt       = '0;
         state_next.tx_wp        = '0;
         state_next.tx_rp        = '0;
         state_next.tx_cnt       = '0;
         state_next.rx_hold_full = 1'b0;
         state_next.tx_hold_full = 1'b0;
      end

      // fifo head needs settle cycles before it is offered
      if (tx_pop || state_reg.tx_cnt == '0) begin
         state_next.tx_settle = uart_shadow_pkg::TX_SETTLE;
      end else if (state_reg.tx_settle != '0) begin
         state_next.tx_settle = state_reg.tx_settle - 2'h1;
      end

      // transmit output stage
      if (state_reg.fifo_en) begin
         state_next.tx_data  = tx_rdata;
         state_next.tx_valid = state_reg.tx_cnt != '0 && state_reg.tx_settle == '0 && !tx_pop && !flush;
      end else begin
         state_next.tx_data  = state_next.tx_hold;
         state_next.tx_valid = state_next.tx_hold_full;
      end

      // line status flags
      state_next.rx_ready = state_next.fifo_en ? state_next.rx_cnt != '0
                                               : state_next.rx_hold_full;
      state_next.tx_empty = state_next.fifo_en ? state_next.tx_cnt == '0
                                               : !state_next.tx_hold_full;
      state_next.ovr      = ovr_ev;

      // sticky interrupt status, a new event beats a clear
      ev = '0;
      ev[uart_shadow_pkg::INT_RX_BIT]       = state_next.rx_ready && !state_reg.rx_ready;
      ev[uart_shadow_pkg::INT_OVERRUN_BIT]  = ovr_ev;
      ev[uart_shadow_pkg::INT_TX_EMPTY_BIT] = state_next.tx_empty && !state_reg.tx_empty;
      if (done && pwrite && paddr == uart_shadow_pkg::INT_CLEAR_ADDR) begin
         state_next.int_stat = state_reg.int_stat & ~pwdata[IW-1:0];
      end
      state_next.int_stat = state_next.int_stat | ev;
      state_next.irq      = |(state_next.int_stat & state_next.int_en);
   end

   // single state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg          <= '0;
         state_reg.st       <= uart_shadow_pkg::BUS_IDLE;
         state_reg.tx_empty <= 1'b1;
         state_reg.prdata   <= 32'(uart_shadow_pkg::ALIAS_RESET);
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state register
   assign prdata           = state_reg.prdata;
   assign pready           = state_reg.pready;
   assign pslverr          = state_reg.pslverr;
   assign tx_data          = state_reg.tx_data;
   assign tx_valid         = state_reg.tx_valid;
   assign tx_ir_mode       = state_reg.ir_mode;
   assign rx_data_ready    = state_reg.rx_ready;
   assign tx_holding_empty = state_reg.tx_empty;
   assign overrun_err      = state_reg.ovr;
   assign irq              = state_reg.irq;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_alias_setup;
      state_reg.st == uart_shadow_pkg::BUS_IDLE && psel && !penable && alias_hit;
   endsequence

   sequence s_alias_answer;
      pready && !pslverr;
   endsequence

   property p_alias_decode;
      s_alias_setup |=> ##1 s_alias_answer;
   endproperty
   a_alias_decode: assert property (p_alias_decode) else $error("alias address not answered");

   property p_ir_source;
      (!state_reg.fifo_en && state_reg.ir_mode && ir_rx_in_valid && !flush)
         |=> (state_reg.rx_hold == $past(ir_rx_in_data)) && rx_data_ready;
   endproperty
   a_ir_source: assert property (p_ir_source) else $error("infrared byte not held");

   property p_ready_flag;
      // the flag follows the fifo fill, also after the pop that empties it
      (state_reg.fifo_en && !flush) |=> rx_data_ready == (state_reg.rx_cnt != '0);
   endproperty
   a_ready_flag: assert property (p_ready_flag) else $error("data ready not shown");

   property p_hold_overrun;
      (!state_reg.fifo_en && state_reg.rx_hold_full && in_v && !hold_pop)
         |=> overrun_err && state_reg.rx_hold == $past(in_d);
   endproperty
   a_hold_overrun: assert property (p_hold_overrun) else $error("overwrite without overrun");

   property p_rx_pop;
      (rx_fpop && !rx_push && !flush) |=> state_reg.rx_cnt == $past(state_reg.rx_cnt) - CW'(1);
   endproperty
   a_rx_pop: assert property (p_rx_pop) else $error("fifo read did not pop");

   property p_rx_full_drop;
      (state_reg.fifo_en && state_reg.rx_cnt == CNT_FULL && in_v && !rd_alias && !flush)
         |=> overrun_err && $stable(state_reg.rx_cnt) && $stable(state_reg.rx_wp);
   endproperty
   a_rx_full_drop: assert property (p_rx_full_drop) else $error("full fifo took a byte");

   property p_tx_hold_load;
      (wr_alias && !state_reg.fifo_en && !flush)
         |=> tx_valid && !tx_holding_empty && tx_data == $past(pwdata[7:0]);
   endproperty
   a_tx_hold_load: assert property (p_tx_hold_load) else $error("holding byte not loaded");

   property p_tx_fifo_accept;
      (tx_push && !tx_pop && !flush) |=> state_reg.tx_cnt == $past(state_reg.tx_cnt) + CW'(1);
   endproperty
   a_tx_fifo_accept: assert property (p_tx_fifo_accept) else $error("fifo write not taken");

   property p_tx_full_drop;
      (wr_alias && state_reg.fifo_en && state_reg.tx_cnt == CNT_FULL && !tx_pop && !flush)
         |=> $stable(state_reg.tx_cnt) && $stable(state_reg.tx_wp);
   endproperty
   a_tx_full_drop: assert property (p_tx_full_drop) else $error("full fifo changed");

   property p_upper_zero;
      (pready && alias_hit) |-> prdata[31:uart_shadow_pkg::DATA_W] == '0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("reserved bits not zero");
endmodule : uart_shadow_data_port
`default_nettype wire

//--- verif/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   input  wire logic       tx_ir_mode,
   output var  logic       rx_in_valid,
   output var  logic [7:0] rx_in_data,
   output var  logic       ir_rx_in_valid,
   output var  logic [7:0] ir_rx_in_data,
   output var  logic       tx_taken
);
   logic       stall = 1'b0;
   logic [8:0] sent[$];
   // idle receive lines
   initial begin
      rx_in_valid    = 1'b0;
      ir_rx_in_valid = 1'b0;
      rx_in_data     = 8'h00;
      ir_rx_in_data  = 8'hff;
   end
   // byte on the chosen line, its inverse as traffic on the other line
   task automatic send(input logic ir, input logic [7:0] d);
      @(posedge pclk);
      rx_in_valid    <= 1'b1;
      ir_rx_in_valid <= 1'b1;
      rx_in_data     <= ir ? ~d : d;
      ir_rx_in_data  <= ir ? d : ~d;
      @(posedge pclk);
      rx_in_valid    <= 1'b0;
      ir_rx_in_valid <= 1'b0;
      rx_in_data     <= ir ? d : ~d;  // released line shows no stale byte
      ir_rx_in_data  <= ir ? ~d : d;
   endtask : send
   // serializer: takes a byte one cycle after it is offered unless stalled
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_taken <= 1'b0;
      end else begin
         if (tx_taken && tx_valid) begin
            sent.push_back({tx_ir_mode, tx_data});
         end
         tx_taken <= tx_valid && !tx_taken && !stall;
      end
   end
endmodule : serial_peer
`default_nettype wire

//--- verif/uart_shadow_data_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uart_shadow_data_port_tb;
   localparam int          DEP   = 4;
   localparam int          LIMIT = 6000;
   localparam logic [31:0] AB    = uart_shadow_pkg::ALIAS_BASE;
   localparam logic [31:0] A1    = uart_shadow_pkg::SHADOW_RX_TX_DATA_ALIAS_1;
   localparam logic [31:0] CTL   = uart_shadow_pkg::CTRL_ADDR;
   localparam logic [31:0] LS    = uart_shadow_pkg::LINE_STATUS_ADDR;
   localparam int          OVB   = uart_shadow_pkg::INT_OVERRUN_BIT;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [31:0] paddr   = 32'h0;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata, q;
   logic [7:0]  rx_in_data, ir_rx_in_data, tx_data;
   logic        pready, pslverr, rx_in_valid, ir_rx_in_valid, tx_taken, tx_valid, tx_ir_mode;
   logic        rx_data_ready, tx_holding_empty, overrun_err, irq, e;
   int          n_mismatch = 0;
   int          tests_run  = 0;
   int          cycles     = 0;
   int          n_ovr      = 0;
   always #5 pclk = ~pclk;
   uart_shadow_data_port #(.DEPTH(DEP)) uart_shadow_data_port_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in_valid(rx_in_valid),
      .rx_in_data(rx_in_data), .ir_rx_in_valid(ir_rx_in_valid), .ir_rx_in_data(ir_rx_in_data),
      .tx_taken(tx_taken), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ir_mode(tx_ir_mode),
      .rx_data_ready(rx_data_ready), .tx_holding_empty(tx_holding_empty), .overrun_err(overrun_err), .irq(irq));
   serial_peer serial_peer_i (
      .pclk(pclk), .presetn(presetn), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ir_mode(tx_ir_mode),
      .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data), .ir_rx_in_valid(ir_rx_in_valid),
      .ir_rx_in_data(ir_rx_in_data), .tx_taken(tx_taken));
   // cycle limit and overrun pulse count
   always @(posedge pclk) begin
      cycles++;
      if (overrun_err === 1'b1) n_ovr++;
      if (cycles == LIMIT) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // apb transfer: setup, access held until pready, result taken at that edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : bus
   task automatic s_reset();
      chk("holding_empty", 32'h1, 32'(tx_holding_empty));
      bus(1'b0, A1, 32'h0);
      chk("alias_reset", 32'(uart_shadow_pkg::ALIAS_RESET), q);
   endtask : s_reset
   task automatic s_rx_modes();
      bus(1'b1, CTL, 32'h0);
      serial_peer_i.send(1'b0, 8'h5a);
      bus(1'b0, LS, 32'h0);
      chk("ready_bit", 32'h1, 32'(q[uart_shadow_pkg::LS_DATA_READY_BIT]));
      bus(1'b0, A1, 32'h0);
      chk("rx_normal", 32'h5a, q);
      repeat (2) @(posedge pclk);
      chk("ready_after_pop", 32'h0, 32'(rx_data_ready));
      bus(1'b1, CTL, 32'h2);
      repeat (2) @(posedge pclk);
      chk("ir_mode", 32'h1, 32'(tx_ir_mode));
      for (int i = 0; i < 16; i++) begin
         serial_peer_i.send(1'b1, 8'hc0 + 8'(i));
         bus(1'b0, AB + 32'(4 * i), 32'h0);
         chk("rx_ir_alias", 32'hc0 + 32'(i), q);
      end
   endtask : s_rx_modes
   task automatic s_rx_overrun();
      int n0;
      bus(1'b1, CTL, 32'h0);
      bus(1'b1, uart_shadow_pkg::INT_CLEAR_ADDR, 32'h7);
      bus(1'b1, uart_shadow_pkg::INT_ENABLE_ADDR, 32'h1 << OVB);
      n0 = n_ovr;
      serial_peer_i.send(1'b0, 8'h11);
      serial_peer_i.send(1'b0, 8'h22);
      repeat (3) @(posedge pclk);
      chk("ovr_pulse", 32'(n0 + 1), 32'(n_ovr));
      chk("irq_set", 32'h1, 32'(irq));
      bus(1'b0, uart_shadow_pkg::INT_STATUS_ADDR, 32'h0);
      chk("int_status", 32'h3, q);
      bus(1'b0, LS, 32'h0);
      chk("line_status_ovr", 32'h23, q);
      bus(1'b0, A1, 32'h0);
      chk("rx_overwritten", 32'h22, q);
      bus(1'b1, uart_shadow_pkg::INT_ENABLE_ADDR, 32'h0);
      repeat (2) @(posedge pclk);
      chk("irq_masked", 32'h0, 32'(irq));
      bus(1'b1, uart_shadow_pkg::INT_ENABLE_ADDR, 32'h1 << OVB);
      bus(1'b1, uart_shadow_pkg::INT_CLEAR_ADDR, 32'h1 << OVB);
      repeat (2) @(posedge pclk);
      chk("irq_cleared", 32'h0, 32'(irq));
   endtask : s_rx_overrun
   task automatic s_rx_fifo();
      int n0;
      bus(1'b1, CTL, 32'h1);
      n0 = n_ovr;
      for (int i = 0; i <= DEP; i++) serial_peer_i.send(1'b0, 8'h10 + 8'(i));
      repeat (3) @(posedge pclk);
      chk("full_ovr", 32'(n0 + 1), 32'(n_ovr));
      for (int i = 0; i < DEP; i++) begin
         bus(1'b0, AB + 32'(4 * i), 32'h0);
         chk("fifo_order", 32'h10 + 32'(i), q);
      end
      bus(1'b0, LS, 32'h0);
      chk("fifo_drained", 32'h0, 32'(q[uart_shadow_pkg::LS_DATA_READY_BIT]));
   endtask : s_rx_fifo
   task automatic s_tx_single();
      serial_peer_i.stall <= 1'b1;
      bus(1'b1, CTL, 32'h0);
      serial_peer_i.sent.delete();
      bus(1'b0, LS, 32'h0);
      chk("tx_empty_first", 32'h1, 32'(q[uart_shadow_pkg::LS_TX_EMPTY_BIT]));
      bus(1'b1, A1, 32'hffff_ff41);
      repeat (2) @(posedge pclk);
      chk("tx_empty_cleared", 32'h0, 32'(tx_holding_empty));
      bus(1'b1, AB, 32'h0000_ab42);
      repeat (2) @(posedge pclk);
      chk("tx_replaced", 32'h42, 32'(tx_data));
      serial_peer_i.stall <= 1'b0;
      while (serial_peer_i.sent.size() == 0) @(posedge pclk);
      repeat (8) @(posedge pclk);
      chk("tx_count", 32'h1, 32'(serial_peer_i.sent.size()));
      chk("tx_byte", 32'h042, 32'(serial_peer_i.sent[0]));
   endtask : s_tx_single
   task automatic s_tx_fifo();
      serial_peer_i.stall <= 1'b1;
      bus(1'b1, CTL, 32'h3);
      serial_peer_i.sent.delete();
      for (int i = 0; i <= DEP; i++) bus(1'b1, AB + 32'(4 * i), 32'h60 + 32'(i));
      serial_peer_i.stall <= 1'b0;
      while (serial_peer_i.sent.size() < DEP) @(posedge pclk);
      repeat (20) @(posedge pclk);
      chk("tx_fifo_count", 32'(DEP), 32'(serial_peer_i.sent.size()));
      for (int i = 0; i < DEP; i++) chk("tx_fifo_byte", 32'h160 + 32'(i), 32'(serial_peer_i.sent[i]));
   endtask : s_tx_fifo
   task automatic s_unmapped();
      bus(1'b0, AB + 32'h40, 32'h0);
      chk("past_window_err", 32'h1, 32'(e));
      chk("past_window_data", 32'h0, q);
   endtask : s_unmapped
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run
   // reset for four cycles, then the scenarios in turn
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      s_reset();
      s_rx_modes();
      s_rx_overrun();
      s_rx_fifo();
      s_tx_single();
      s_tx_fifo();
      s_unmapped();
      complete_run();
   end
endmodule : uart_shadow_data_port_tb
`default_nettype wire
